// >>> twr_pkg.sv
package twr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_COUNT_LO  = 8'h04;
  localparam logic [7:0] OFS_COUNT_HI  = 8'h08;
  localparam logic [7:0] OFS_FLAG      = 8'h0C;
  localparam logic [7:0] OFS_FLAG_CLR  = 8'h10;
  localparam logic [7:0] OFS_ENABLE    = 8'h14;
  localparam logic [7:0] OFS_CMP_CTRL  = 8'h18;
  localparam logic [7:0] OFS_CMP_LO    = 8'h1C;
  localparam logic [7:0] OFS_CMP_HI    = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned CTL_ON_BIT   = 0;
  localparam int unsigned CTL_EXT_BIT  = 1;
  localparam int unsigned CTL_OSC_BIT  = 3;
  localparam int unsigned CTL_WIDE_BIT = 7;
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam int unsigned IEN_OVF_BIT  = 0;
  localparam int unsigned CMP_MODE_LSB = 0;
  localparam int unsigned CMP_ADC_BIT  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and encodings.
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam logic [7:0]  CMP_CTRL_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST      = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [3:0]  MODE_SPECIAL   = 4'hB;
  localparam int unsigned PRESCALE_DEF   = 1;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } twr_bus_state_t;

endpackage

// >>> twr_sync.sv
`timescale 1ns/10ps
`default_nettype none

module twr_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic stage_one;

  ////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second one, to let metastability settle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_one <= 1'b0;
      sync_out  <= 1'b0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule
`default_nettype wire

// >>> twr_compare.sv
`timescale 1ns/10ps
`default_nettype none

module twr_compare
(
  input  wire logic [15:0] count,
  input  wire logic [15:0] period,
  input  wire logic [3:0]  compare_mode_field,
  input  wire logic        tick,
  output var  logic        special_trigger
);

  import twr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Matching on the tick that would pass the period makes the period inclusive.
  always_comb
  begin
    special_trigger = tick && (compare_mode_field == MODE_SPECIAL) && (count == period);
  end

endmodule
`default_nettype wire

// >>> twr_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Oscillator enabled only while control bit three set
// - Oscillator keeps running during sleep
// - Count rolls FFFFh to 0000h
// - Roll-over sets sticky overflow flag
// - Overflow request gated by enable bit
// - Mode 1011 match resets count, starts conversion
// - Count byte write beats coincident trigger reset
// - Compare value pair sets the period
// - Wide mode maps high address to buffer
// - Low read copies live high into buffer
// - Low write loads high from buffer
// - Wide mode hides the live high byte
// - Only low write clears the prescaler
module twr_timer
#(
  parameter int unsigned PRESCALE_DIV = twr_pkg::PRESCALE_DEF
)
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [twr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [twr_pkg::DATA_W-1:0] pwdata,
  output var  logic [twr_pkg::DATA_W-1:0] prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  input  wire logic                       crystal_in_pin,
  output var  logic                       crystal_osc_enable,
  output var  logic                       adc_start,
  output var  logic                       overflow_irq
);

  import twr_pkg::*;

  localparam int unsigned PS_W = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(PRESCALE_DIV - 1);
  localparam logic [PS_W-1:0] PS_ZERO = '0;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == OFS_CONTROL) || (a == OFS_COUNT_LO) || (a == OFS_COUNT_HI) ||
                  (a == OFS_FLAG) || (a == OFS_FLAG_CLR) || (a == OFS_ENABLE) ||
                  (a == OFS_CMP_CTRL) || (a == OFS_CMP_LO) || (a == OFS_CMP_HI);
  endfunction

  twr_bus_state_t state;
  twr_bus_state_t next_state;
  logic [7:0]        timer_control_reg;
  logic [7:0]        next_timer_control_reg;
  logic [7:0]        cmp_ctrl;
  logic [7:0]        next_cmp_ctrl;
  logic [7:0]        compare_value_low;
  logic [7:0]        next_compare_value_low;
  logic [7:0]        compare_value_high;
  logic [7:0]        next_compare_value_high;
  logic [15:0]       count;
  logic [15:0]       next_count;
  logic [7:0]        high_buffer;
  logic [7:0]        next_high_buffer;
  logic [PS_W-1:0]   prescale;
  logic [PS_W-1:0]   next_prescale;
  logic              overflow_flag;
  logic              next_overflow_flag;
  logic              overflow_irq_enable;
  logic              next_overflow_irq_enable;
  logic [DATA_W-1:0] next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_adc_start;
  logic              next_overflow_irq;
  logic              ext_sync;
  logic              ext_prev;
  logic              source_event;
  logic              tick;
  logic              special_trigger;
  logic              wide_access_select;
  logic              do_write;
  logic              do_read_start;
  logic              wr_low;
  logic              wr_high;

  ////////////////////////////////////////////////////////////////////////////
  // Counter-mode input from the crystal pin is resynchronised before use.
  // Only synchronised counting is offered, so the trigger reset works unless a count byte write lands in the same cycle.
  twr_sync u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (crystal_in_pin),
    .sync_out (ext_sync)
  );

  twr_compare u_compare
  (
    .count              (count),
    .period             ({compare_value_high, compare_value_low}),
    .compare_mode_field (cmp_ctrl[CMP_MODE_LSB +: 4]),
    .tick               (tick),
    .special_trigger    (special_trigger)
  );

  always_comb
  begin
    wide_access_select = timer_control_reg[CTL_WIDE_BIT];
    source_event  = timer_control_reg[CTL_EXT_BIT] ? (ext_sync && !ext_prev) : 1'b1;
    tick          = timer_control_reg[CTL_ON_BIT] && source_event && (prescale == PS_LAST);
    do_write      = (state == ST_ANSWER) && psel && penable && pwrite;
    do_read_start = (state == ST_IDLE) && psel && penable && !pwrite;
    wr_low        = do_write && (paddr == OFS_COUNT_LO);
    wr_high       = do_write && (paddr == OFS_COUNT_HI);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then pready for one cycle.
  always_comb
  begin
    next_state   = state;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (psel && penable)
        begin
          next_state   = ST_ANSWER;
          next_pready  = 1'b1;
          next_pslverr = !addr_mapped(paddr) || (!pwrite && (paddr == OFS_FLAG_CLR));
        end
      end
      ST_ANSWER:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured as the answer is raised.
  always_comb
  begin
    next_prdata = prdata;
    if (do_read_start)
    begin
      next_prdata = '0;
      unique case (paddr)
        OFS_CONTROL:  next_prdata[7:0] = timer_control_reg;
        OFS_COUNT_LO: next_prdata[7:0] = count[7:0];
        OFS_COUNT_HI: next_prdata[7:0] = wide_access_select ? high_buffer : count[15:8];
        OFS_FLAG:     next_prdata[FLAG_OVF_BIT] = overflow_flag;
        OFS_ENABLE:   next_prdata[IEN_OVF_BIT] = overflow_irq_enable;
        OFS_CMP_CTRL: next_prdata[7:0] = cmp_ctrl;
        OFS_CMP_LO:   next_prdata[7:0] = compare_value_low;
        OFS_CMP_HI:   next_prdata[7:0] = compare_value_high;
        default:      next_prdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_comb
  begin
    next_timer_control_reg   = timer_control_reg;
    next_cmp_ctrl            = cmp_ctrl;
    next_compare_value_low   = compare_value_low;
    next_compare_value_high  = compare_value_high;
    next_overflow_irq_enable = overflow_irq_enable;
    if (do_write)
    begin
      unique case (paddr)
        OFS_CONTROL:  next_timer_control_reg = pwdata[7:0];
        OFS_ENABLE:   next_overflow_irq_enable = pwdata[IEN_OVF_BIT];
        OFS_CMP_CTRL: next_cmp_ctrl = pwdata[7:0];
        OFS_CMP_LO:   next_compare_value_low = pwdata[7:0];
        OFS_CMP_HI:   next_compare_value_high = pwdata[7:0];
        default:      next_timer_control_reg = timer_control_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count, high byte buffer and prescaler.
  always_comb
  begin
    next_count       = count;
    next_high_buffer = high_buffer;
    next_prescale    = prescale;
    if (timer_control_reg[CTL_ON_BIT] && source_event)
    begin
      next_prescale = (prescale == PS_LAST) ? PS_ZERO : prescale + PS_W'(1);
    end
    if (tick)
    begin
      // A count byte write in this cycle discards the trigger reset entirely.
      next_count = (special_trigger && !wr_low && !wr_high) ? COUNT_RST
                 : count + 16'h0001;
    end
    if (do_read_start && (paddr == OFS_COUNT_LO) && wide_access_select)
    begin
      next_high_buffer = count[15:8];
    end
    // A write lands after the tick logic above, so it overrides a trigger reset.
    if (wr_low)
    begin
      next_count[7:0] = pwdata[7:0];
      next_prescale   = PS_ZERO;
      if (wide_access_select)
      begin
        next_count[15:8] = high_buffer;
      end
    end
    if (wr_high)
    begin
      if (wide_access_select)
      begin
        next_high_buffer = pwdata[7:0];
      end
      else
      begin
        next_count[15:8] = pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag, interrupt and converter start.
  always_comb
  begin
    next_overflow_flag = overflow_flag;
    if (do_write && (paddr == OFS_FLAG_CLR) && pwdata[FLAG_OVF_BIT])
    begin
      next_overflow_flag = 1'b0;
    end
    // A roll-over in the clearing cycle still sets the flag.
    if (tick && !special_trigger && (count == COUNT_MAX) && !wr_low && !wr_high)
    begin
      next_overflow_flag = 1'b1;
    end
    next_overflow_irq = next_overflow_flag && next_overflow_irq_enable;
    next_adc_start    = special_trigger && cmp_ctrl[CMP_ADC_BIT] && !wr_low && !wr_high;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The oscillator follows its enable bit only; sleep does not gate it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state               <= ST_IDLE;
      prdata              <= '0;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      timer_control_reg   <= CONTROL_RST;
      cmp_ctrl            <= CMP_CTRL_RST;
      compare_value_low   <= BYTE_RST;
      compare_value_high  <= BYTE_RST;
      count               <= COUNT_RST;
      high_buffer         <= BYTE_RST;
      prescale            <= PS_ZERO;
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      overflow_irq        <= 1'b0;
      adc_start           <= 1'b0;
      ext_prev            <= 1'b0;
      crystal_osc_enable  <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      prdata              <= next_prdata;
      pready              <= next_pready;
      pslverr             <= next_pslverr;
      timer_control_reg   <= next_timer_control_reg;
      cmp_ctrl            <= next_cmp_ctrl;
      compare_value_low   <= next_compare_value_low;
      compare_value_high  <= next_compare_value_high;
      count               <= next_count;
      high_buffer         <= next_high_buffer;
      prescale            <= next_prescale;
      overflow_flag       <= next_overflow_flag;
      overflow_irq_enable <= next_overflow_irq_enable;
      overflow_irq        <= next_overflow_irq;
      adc_start           <= next_adc_start;
      ext_prev            <= ext_sync;
      crystal_osc_enable  <= next_timer_control_reg[CTL_OSC_BIT];
    end
  end

endmodule
`default_nettype wire

// >>> twr_timer_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module twr_timer_monitor
  import twr_pkg::*;
#(
  parameter int unsigned PRESCALE_DIV = 1
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        crystal_in_pin,
  input wire logic        crystal_osc_enable,
  input wire logic        adc_start,
  input wire logic        overflow_irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_ctl_wr;
    s_done ##0 (pwrite && paddr == OFS_CONTROL);
  endsequence

  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("ready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (s_done ##0 (paddr > OFS_CMP_HI) |-> pslverr)
    else $error("unmapped access not refused");
  a_rdata_byte: assert property (s_done ##0 !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_osc_follow: assert property (s_ctl_wr |-> ##2 crystal_osc_enable == $past(pwdata[3], 2))
    else $error("oscillator enable does not follow control");
  a_adc_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  a_irq_fall: assert property ($fell(overflow_irq) |-> $past(psel && pwrite && pready))
    else $error("interrupt dropped without a bus write");
endmodule

bind twr_timer twr_timer_monitor #(.PRESCALE_DIV(PRESCALE_DIV)) twr_timer_monitor_inst
(
  .pclk               (pclk),
  .presetn            (presetn),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .prdata             (prdata),
  .pready             (pready),
  .pslverr            (pslverr),
  .crystal_in_pin     (crystal_in_pin),
  .crystal_osc_enable (crystal_osc_enable),
  .adc_start          (adc_start),
  .overflow_irq       (overflow_irq)
);
`default_nettype wire

// >>> twr_xtal_model.sv
`timescale 1ns/10ps
`default_nettype none

module twr_xtal_model
#(
  parameter int unsigned STARTUP = 8,
  parameter int unsigned HALF    = 3
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_enable,
  output var logic crystal_in_pin
);
  int unsigned start_cnt;
  int unsigned phase;

  // The crystal has no sleep input, so it runs whenever enabled.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn || !osc_enable)
    begin
      start_cnt <= 0;
      phase <= 0;
      crystal_in_pin <= 1'b0;
    end
    else if (start_cnt < STARTUP)
      start_cnt <= start_cnt + 1;
    else if (phase == HALF - 1)
    begin
      phase <= 0;
      crystal_in_pin <= !crystal_in_pin;
    end
    else
      phase <= phase + 1;
  end
endmodule
`default_nettype wire

// >>> twr_timer_test.sv
`timescale 1ns/10ps
`default_nettype none

module twr_timer_test;
  import twr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xtal;
  logic        osc_en;
  logic        adc_start;
  logic        overflow_irq;
  int          n_errors;
  int          n_compared;
  logic [31:0] v;
  logic        e;
  int          n;

  twr_timer twr_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_in_pin(xtal),
    .crystal_osc_enable(osc_en), .adc_start(adc_start), .overflow_irq(overflow_irq));
  twr_xtal_model twr_xtal_model_inst (.pclk(pclk), .presetn(presetn),
    .osc_enable(osc_en), .crystal_in_pin(xtal));

  always #12.5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask

  // Requests stay up until pready is seen at an edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      chk("pready", 1, 0);
      stop_test;
    end
    // One idle edge keeps the next call from driving psel in this same step.
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask

  task rdc(input string s, input logic [7:0] a, input logic [7:0] x);
    xfer(1'b0, a, 32'h00000000);
    chk(s, {24'h000000, x}, v);
  endtask

  // Counts edges until the chosen output is seen high.
  task wait_sig(input logic adc, input int lim, input logic must);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while ((adc ? adc_start : overflow_irq) !== 1'b1 && n < lim);
    if (must && n >= lim)
    begin
      chk("wait", 1, 0);
      stop_test;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_osc;
    chk("osc_rst", 0, osc_en);
    wr(OFS_CONTROL, 8'h08);
    rdc("ctl", OFS_CONTROL, 8'h08);
    chk("osc_on", 1, osc_en);
    $display("t_osc done");
  endtask

  task t_wide;
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_COUNT_HI, 8'hAB);
    wr(OFS_COUNT_LO, 8'hCD);
    rdc("hi_live", OFS_COUNT_HI, 8'hAB);
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_COUNT_HI, 8'h77);
    rdc("hi_buf", OFS_COUNT_HI, 8'h77);
    rdc("lo", OFS_COUNT_LO, 8'hCD);
    rdc("hi_snap", OFS_COUNT_HI, 8'hAB);
    wr(OFS_COUNT_HI, 8'h12);
    wr(OFS_COUNT_LO, 8'h34);
    wr(OFS_CONTROL, 8'h00);
    rdc("hi_load", OFS_COUNT_HI, 8'h12);
    rdc("lo_load", OFS_COUNT_LO, 8'h34);
    $display("t_wide done");
  endtask

  task t_roll;
    wr(OFS_COUNT_HI, 8'hFF);
    wr(OFS_COUNT_LO, 8'hF0);
    wr(OFS_ENABLE, 8'h01);
    wr(OFS_CONTROL, 8'h01);
    wait_sig(1'b0, 100, 1'b1);
    rdc("flag", OFS_FLAG, 8'h01);
    rdc("hi_wrap", OFS_COUNT_HI, 8'h00);
    wr(OFS_ENABLE, 8'h00);
    @(posedge pclk);
    chk("irq_off", 0, overflow_irq);
    wr(OFS_FLAG_CLR, 8'h01);
    rdc("flag_clr", OFS_FLAG, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    xfer(1'b0, 8'h40, 32'h00000000);
    chk("unmapped", 1, e);
    $display("t_roll done");
  endtask

  task t_trig;
    wr(OFS_CMP_LO, 8'h05);
    wr(OFS_CMP_HI, 8'h00);
    wr(OFS_CMP_CTRL, 8'h1B);
    wr(OFS_COUNT_LO, 8'h00);
    wr(OFS_CONTROL, 8'h01);
    wait_sig(1'b1, 100, 1'b1);
    wait_sig(1'b1, 100, 1'b1);
    chk("period", 6, n);
    rdc("no_flag", OFS_FLAG, 8'h00);
    wr(OFS_CMP_CTRL, 8'h0B);
    wait_sig(1'b1, 20, 1'b0);
    chk("no_adc", 20, n);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_CMP_LO, 8'h00);
    wr(OFS_COUNT_LO, 8'h00);
    wr(OFS_CONTROL, 8'h01);
    wr(OFS_COUNT_LO, 8'h55);
    xfer(1'b0, OFS_COUNT_LO, 32'h00000000);
    chk("wr_wins", 1, v[7:0] > 8'h54 && v[7:0] < 8'h60);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_CMP_CTRL, 8'h00);
    $display("t_trig done");
  endtask

  task t_count;
    int k;
    wr(OFS_COUNT_LO, 8'h00);
    wr(OFS_CONTROL, 8'h0B);
    k = 0;
    do
    begin
      xfer(1'b0, OFS_COUNT_LO, 32'h00000000);
      k++;
    end while (v === 32'h00000000 && k < 20);
    chk("ext_count", 1, v !== 32'h00000000);
    $display("t_count done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_osc;
    t_wide;
    t_roll;
    t_trig;
    t_count;
    stop_test;
  end
endmodule
`default_nettype wire
